// [hdl/atu_pkg.sv]
// package of constants and types for the dsp address translation unit
package atu_pkg;
	// ==========================================================
	// register offsets (word addresses on the plain register port)
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_TAG_HI = 4'h1;
	localparam logic [3:0] REG_TAG_LO = 4'h2;
	localparam logic [3:0] REG_DATA_HI = 4'h3;
	localparam logic [3:0] REG_DATA_LO = 4'h4;
	localparam logic [3:0] REG_LOCK = 4'h5;
	localparam logic [3:0] REG_LOAD = 4'h6;
	localparam logic [3:0] REG_IRQ_STAT = 4'h7;
	localparam logic [3:0] REG_IRQ_MASK = 4'h8;
	localparam logic [3:0] REG_FAULT_ADDR = 4'h9;
	localparam logic [3:0] REG_FAULT_CAUSE = 4'ha;
	// ==========================================================
	// field positions
	localparam int TLO_SIZE_LSB = 0;
	localparam int TLO_PRES_BIT = 3;
	localparam int TLO_VALID_BIT = 2;
	localparam int TLO_TAG2_LSB = 4;
	localparam int TLO_TAG1_LSB = 14;
	localparam int DLO_PERM_LSB = 8;
	localparam int DLO_PHYS_LSB = 10;
	localparam int LOCK_CUR_LSB = 4;
	localparam int IRQ_PAGE_BIT = 0;
	localparam int IRQ_PERM_BIT = 1;
	// ==========================================================
	// widths and reset values
	localparam int VA_W = 24;
	localparam int PA_W = 32;
	localparam int ENTRIES = 32;
	localparam int IDX_W = 5;
	localparam int TAG_W = 14;
	localparam logic [7:0] PASS_HI = 8'h00;
	localparam logic CTRL_EN_RST = 1'b0;
	// ==========================================================
	// page sizes and permissions
	typedef enum logic [1:0] {
		PG_1K = 2'h0,
		PG_64K = 2'h1,
		PG_4K = 2'h2,
		PG_1M = 2'h3
	} page_size_t;
	typedef enum logic [1:0] {
		PERM_NONE = 2'h0,
		PERM_RO = 2'h2,
		PERM_RW = 2'h3
	} perm_t;
	typedef struct packed {
		logic [TAG_W-1:0] tag;
		logic pres;
		logic valid;
		page_size_t size;
	} tag_ent_t;
	typedef struct packed {
		logic [21:0] phys;
		perm_t perm;
	} data_ent_t;
endpackage : atu_pkg

// [hdl/atu_lookup_if.sv]
// interface between translation top and tag/data match array
`timescale 1ns/100ps
interface atu_lookup_if;
	import atu_pkg::*;
	logic [atu_pkg::VA_W-1:0] va;
	logic hit;
	atu_pkg::data_ent_t data;
	atu_pkg::page_size_t size;
	logic wr_en;
	logic [atu_pkg::IDX_W-1:0] wr_idx;
	atu_pkg::tag_ent_t wr_tag;
	atu_pkg::data_ent_t wr_data;
	modport top (output va, wr_en, wr_idx, wr_tag, wr_data, input hit, data, size);
	modport arr (input va, wr_en, wr_idx, wr_tag, wr_data, output hit, data, size);
endinterface : atu_lookup_if

// [hdl/atu_tlb_array.sv]
// 32-entry tag cam with index-paired data ram
`timescale 1ns/100ps
module atu_tlb_array (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// lookup and load
	atu_lookup_if.arr lk
);
	import atu_pkg::*;
	// ==========================================================
	// storage arrays
	tag_ent_t tag_r [ENTRIES];
	data_ent_t data_r [ENTRIES];

	// significant tag bits of va for a page size
	function automatic logic [TAG_W-1:0] tag_mask(input page_size_t s);
		unique case (s)
			PG_1M: tag_mask = 14'h3c00;
			PG_64K: tag_mask = 14'h3fc0;
			PG_4K: tag_mask = 14'h3ffc;
			PG_1K: tag_mask = 14'h3fff;
		endcase
	endfunction : tag_mask

	// load port; tags reset to invalid 1k pages so no unknown size reaches the mask
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < ENTRIES; i++) tag_r[i] <= '0;
		end else if (lk.wr_en) begin
			tag_r[lk.wr_idx] <= lk.wr_tag;
			data_r[lk.wr_idx] <= lk.wr_data;
		end
	end

	// parallel compare; lowest index wins if software loads duplicates
	always_comb begin
		logic [TAG_W-1:0] m;
		m = '0;
		lk.hit = 1'b0;
		lk.data = '0;
		lk.size = PG_1K;
		for (int i = ENTRIES-1; i >= 0; i--) begin
			m = tag_mask(tag_r[i].size);
			if (tag_r[i].valid && ((tag_r[i].tag & m) == (lk.va[23:10] & m))) begin
				lk.hit = 1'b1;
				lk.data = data_r[i];
				lk.size = tag_r[i].size;
			end
		end
	end
endmodule : atu_tlb_array

// [hdl/atu_top.sv]
// dsp address translation unit top: register port, lookup, fault handling
// Contract
// - map each 24-bit dsp external address to a 32-bit system address
// - reset leaves translation off; off means passthrough to lowest 16M bytes
// - table is 32 tag entries paired by index with 32 data entries
// - tag entry holds tag, preserved bit, valid bit, page size code
// - data entry holds upper physical bits and none/read-only/read-write permission
// - when on, compare upper va bits against valid tags, index data array
// - permitted access forwards translated address to system traffic controller
// - no match is page fault; forbidden access is permission fault
// - any fault raises interrupt toward host
// - fault cause kept in host-readable registers
// - only accesses outside internal memory pass through this unit
// - page size code selects 1M, 64K, 4K or 1K byte pages
// - load tag hi/lo, data hi/lo, lock counter, then strobe load
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
module atu_top (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_n_i,
	// register port
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	// dsp request side
	input wire logic dsp_req_i,
	input wire logic dsp_we_i,
	input wire logic dsp_internal_i,
	input wire logic [atu_pkg::VA_W-1:0] dsp_va_i,
	output logic dsp_fault_o,
	// system traffic controller side
	output logic stc_req_o,
	output logic stc_we_o,
	output logic [atu_pkg::PA_W-1:0] stc_addr_o,
	// interrupt
	output logic irq_o
);
	import atu_pkg::*;

	// ==========================================================
	// registers
	logic en_r;
	logic [15:0] tag_hi_r, tag_lo_r, data_hi_r, data_lo_r, lock_r;
	logic [1:0] stat_r, mask_r;
	logic [VA_W-1:0] fault_va_r;
	logic fault_we_r;
	logic [15:0] rdata_r;
	logic stc_req_r, stc_we_r, dsp_fault_r;
	logic [PA_W-1:0] stc_addr_r;

	atu_lookup_if lk ();

	atu_tlb_array u_arr (
		.ref_clk_i(ref_clk_i),
		.rst_n_i(rst_n_i),
		.lk(lk.arr)
	);

	// ==========================================================
	// register decode; a load write with bit 0 low is refused so a stray
	// zero write cannot overwrite a live slot
	wire wr_ctrl = reg_wr_i && reg_addr_i == REG_CTRL;
	wire wr_tag_hi = reg_wr_i && reg_addr_i == REG_TAG_HI;
	wire wr_tag_lo = reg_wr_i && reg_addr_i == REG_TAG_LO;
	wire wr_data_hi = reg_wr_i && reg_addr_i == REG_DATA_HI;
	wire wr_data_lo = reg_wr_i && reg_addr_i == REG_DATA_LO;
	wire wr_lock = reg_wr_i && reg_addr_i == REG_LOCK;
	wire wr_load = reg_wr_i && reg_addr_i == REG_LOAD && reg_wdata_i[0];
	wire wr_stat = reg_wr_i && reg_addr_i == REG_IRQ_STAT;
	wire wr_mask = reg_wr_i && reg_addr_i == REG_IRQ_MASK;
	// write-one-clear bits of the status word, zero when it is not addressed
	wire [1:0] clr_bits = wr_stat ? reg_wdata_i[1:0] : 2'h0;

	// assemble the staged entry from the holding words
	// limitation: a loaded slot is always valid; retire it by reloading the slot
	tag_ent_t ld_tag;
	data_ent_t ld_data;
	assign ld_tag.tag = {tag_hi_r[11:0], tag_lo_r[15:TLO_TAG1_LSB]};
	assign ld_tag.pres = tag_lo_r[TLO_PRES_BIT];
	assign ld_tag.valid = 1'b1;
	assign ld_tag.size = page_size_t'(tag_lo_r[TLO_SIZE_LSB +: 2]);
	assign ld_data.phys = {data_hi_r, data_lo_r[15:DLO_PHYS_LSB]};
	assign ld_data.perm = perm_t'(data_lo_r[DLO_PERM_LSB +: 2]);
	assign lk.wr_en = wr_load;
	assign lk.wr_idx = lock_r[LOCK_CUR_LSB +: IDX_W];
	assign lk.wr_tag = ld_tag;
	assign lk.wr_data = ld_data;

	// ==========================================================
	// translation datapath
	wire ext_req = dsp_req_i && !dsp_internal_i;
	assign lk.va = dsp_va_i;

	// offset bits kept from the va are set by the page size
	function automatic logic [PA_W-1:0] form_pa(input logic [21:0] ph,
		input logic [VA_W-1:0] va, input page_size_t s);
		logic [PA_W-1:0] b;
		b = {ph, 10'h000};
		unique case (s)
			PG_1M: form_pa = {b[31:20], va[19:0]};
			PG_64K: form_pa = {b[31:16], va[15:0]};
			PG_4K: form_pa = {b[31:12], va[11:0]};
			PG_1K: form_pa = {b[31:10], va[9:0]};
		endcase
	endfunction : form_pa

	// codes 0 and 1 both deny; only read-only and read-write grant anything
	wire perm_ok = (lk.data.perm == PERM_RW) || (lk.data.perm == PERM_RO && !dsp_we_i);
	wire page_flt = ext_req && en_r && !lk.hit;
	wire perm_flt = ext_req && en_r && lk.hit && !perm_ok;
	wire pass_ok = ext_req && (!en_r || perm_ok && lk.hit);
	wire [PA_W-1:0] pa_nxt = en_r ? form_pa(lk.data.phys, dsp_va_i, lk.size)
		: {PASS_HI, dsp_va_i};
	wire [1:0] ev = {perm_flt, page_flt};

	// registered forward toward the traffic controller
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stc_req_r <= 1'b0;
			stc_we_r <= 1'b0;
			stc_addr_r <= '0;
			dsp_fault_r <= 1'b0;
		end else begin
			stc_req_r <= pass_ok;
			stc_we_r <= dsp_we_i;
			if (pass_ok) stc_addr_r <= pa_nxt;
			dsp_fault_r <= page_flt || perm_flt;
		end
	end

	// control and mask; enable resets off so stale entries cannot translate
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			en_r <= CTRL_EN_RST;
			mask_r <= '0;
		end else begin
			if (wr_ctrl) en_r <= reg_wdata_i[0];
			if (wr_mask) mask_r <= reg_wdata_i[1:0];
		end
	end

	// staging words for the next entry; nothing reaches the table before
	// the load strobe, so a half-written entry never matches
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tag_hi_r <= '0;
			tag_lo_r <= '0;
			data_hi_r <= '0;
			data_lo_r <= '0;
			lock_r <= '0;
		end else begin
			if (wr_tag_hi) tag_hi_r <= reg_wdata_i;
			if (wr_tag_lo) tag_lo_r <= reg_wdata_i;
			if (wr_data_hi) data_hi_r <= reg_wdata_i;
			if (wr_data_lo) data_lo_r <= reg_wdata_i;
			if (wr_lock) lock_r <= reg_wdata_i;
		end
	end

	// sticky fault status, set wins over write-one-clear
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			stat_r <= '0;
		end else begin
			stat_r <= (stat_r & ~clr_bits) | ev;
		end
	end

	// first fault address kept until status cleared so software sees the cause
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fault_va_r <= '0;
			fault_we_r <= 1'b0;
		end else if ((|ev) && (stat_r & ~clr_bits) == 2'h0) begin // clear then fault
			fault_va_r <= dsp_va_i;
			fault_we_r <= dsp_we_i;
		end
	end

	// ==========================================================
	// read path, one cycle latency; unmapped reads return zero
	logic [15:0] rd_mux;
	always_comb begin
		unique case (reg_addr_i)
			REG_CTRL: rd_mux = {15'h0000, en_r};
			REG_TAG_HI: rd_mux = tag_hi_r;
			REG_TAG_LO: rd_mux = tag_lo_r;
			REG_DATA_HI: rd_mux = data_hi_r;
			REG_DATA_LO: rd_mux = data_lo_r;
			REG_LOCK: rd_mux = lock_r;
			REG_IRQ_STAT: rd_mux = {14'h0000, stat_r};
			REG_IRQ_MASK: rd_mux = {14'h0000, mask_r};
			REG_FAULT_ADDR: rd_mux = fault_va_r[23:8];
			REG_FAULT_CAUSE: rd_mux = {fault_va_r[7:0], 5'h00, fault_we_r, stat_r};
			default: rd_mux = 16'h0000;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) rdata_r <= '0;
		else if (reg_rd_i) rdata_r <= rd_mux;
		else rdata_r <= '0;
	end

	// ==========================================================
	// outputs
	assign reg_rdata_o = rdata_r;
	assign stc_req_o = stc_req_r;
	assign stc_we_o = stc_we_r;
	assign stc_addr_o = stc_addr_r;
	assign dsp_fault_o = dsp_fault_r;
	assign irq_o = |(stat_r & mask_r);

	// ==========================================================
	// assertions
	reset_off_a: assert property (@(posedge ref_clk_i) $rose(rst_n_i) |-> !en_r)
		else $error("translation not off after reset");
	pass_hi_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(ext_req && !en_r) |=> (stc_req_o && stc_addr_o[31:24] == 8'h00))
		else $error("passthrough address not in low 16M");
	internal_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(dsp_req_i && dsp_internal_i) |=> !stc_req_o && !dsp_fault_o)
		else $error("internal access reached traffic controller");
	pagef_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		page_flt |=> stat_r[IRQ_PAGE_BIT] && !stc_req_o)
		else $error("page fault not recorded");
	permf_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(ext_req && en_r && lk.hit && lk.data.perm == PERM_RO && dsp_we_i)
		|=> stat_r[IRQ_PERM_BIT])
		else $error("write to read-only page not faulted");
	irq_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(page_flt && mask_r[IRQ_PAGE_BIT] && !wr_mask) |=> irq_o)
		else $error("fault did not raise interrupt");
	sticky_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(stat_r[0] && !(wr_stat && reg_wdata_i[0])) |=> stat_r[0])
		else $error("fault status lost without clear");
	fwd_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(ext_req && en_r && lk.hit && lk.data.perm == PERM_RW)
		|=> stc_req_o && stc_addr_o == $past(pa_nxt))
		else $error("permitted access not forwarded");
	off1k_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(ext_req && en_r && lk.hit && perm_ok) |=> stc_addr_o[9:0] == $past(dsp_va_i[9:0]))
		else $error("page offset not carried");

	// ==========================================================
	// answer, permission and page offset checks
	answer_one_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		ext_req |=> (stc_req_o != dsp_fault_o))
		else $error("external request without exactly one answer");
	no_access_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(ext_req && en_r && lk.hit && lk.data.perm == PERM_NONE)
		|=> dsp_fault_o && stat_r[IRQ_PERM_BIT] && !stc_req_o)
		else $error("no-access page was forwarded");
	ro_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(ext_req && en_r && lk.hit && lk.data.perm == PERM_RO && !dsp_we_i)
		|=> stc_req_o && !stc_we_o)
		else $error("read of read-only page not forwarded");
	ro_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(ext_req && en_r && lk.hit && lk.data.perm == PERM_RO && dsp_we_i)
		|=> dsp_fault_o && !stc_req_o)
		else $error("write to read-only page was forwarded");
	fwd_we_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		pass_ok |=> stc_we_o == $past(dsp_we_i))
		else $error("forwarded direction differs from request");
	pass_addr_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(ext_req && !en_r) |=> stc_addr_o == {PASS_HI, $past(dsp_va_i)})
		else $error("passthrough address differs from dsp address");
	phys_base_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(ext_req && en_r && lk.hit && perm_ok)
		|=> stc_addr_o[31:20] == $past(lk.data.phys[21:10]))
		else $error("page base not taken from data entry");
	off_1m_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(ext_req && en_r && lk.hit && perm_ok && lk.size == PG_1M)
		|=> stc_addr_o[19:0] == $past(dsp_va_i[19:0]))
		else $error("1M page offset not carried");
	off_64k_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(ext_req && en_r && lk.hit && perm_ok && lk.size == PG_64K)
		|=> stc_addr_o[15:0] == $past(dsp_va_i[15:0]))
		else $error("64K page offset not carried");

	// status, interrupt and read port
	clear_page_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(clr_bits[IRQ_PAGE_BIT] && !page_flt) |=> !stat_r[IRQ_PAGE_BIT])
		else $error("page fault status not cleared by a one");
	irq_perm_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(perm_flt && mask_r[IRQ_PERM_BIT] && !wr_mask) |=> irq_o)
		else $error("permission fault did not raise interrupt");
	capture_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		((|ev) && stat_r == 2'h0) |=> fault_va_r == $past(dsp_va_i))
		else $error("fault address not captured");
	mask_off_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		(mask_r == 2'h0 && !wr_mask) |=> !irq_o)
		else $error("interrupt raised while fully masked");
	rd_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		!reg_rd_i |=> reg_rdata_o == 16'h0000)
		else $error("read data shown without a read");
	c_clear: cover property (@(posedge ref_clk_i) wr_stat && (|stat_r));
	c_load: cover property (@(posedge ref_clk_i) wr_load);
	c_fwd: cover property (@(posedge ref_clk_i) en_r && pass_ok);
	c_page: cover property (@(posedge ref_clk_i) page_flt);
	c_perm: cover property (@(posedge ref_clk_i) perm_flt);
endmodule : atu_top

// [testbench/dsp_stc_model.sv]
// dsp requester and traffic controller model facing the translation unit
`timescale 1ns/100ps
module dsp_stc_model (
	// clock
	input wire logic ref_clk_i,
	// dsp request side
	output logic dsp_req_o,
	output logic dsp_we_o,
	output logic dsp_internal_o,
	output logic [23:0] dsp_va_o,
	input wire logic dsp_fault_i,
	// traffic controller side
	input wire logic stc_req_i,
	input wire logic stc_we_i,
	input wire logic [31:0] stc_addr_i
);
	// idle lines at time zero
	initial begin
		dsp_req_o = 1'b0;
		dsp_we_o = 1'b0;
		dsp_internal_o = 1'b0;
		dsp_va_o = 24'h000000;
	end
	// one access held for one cycle; answer taken 1 ns after the taking edge
	task access(input logic we, input logic intl, input logic [23:0] va,
		output logic fwd, output logic flt, output logic wr, output logic [31:0] pa);
		@(posedge ref_clk_i);
		dsp_req_o <= 1'b1;
		dsp_we_o <= we;
		dsp_internal_o <= intl;
		dsp_va_o <= va;
		@(posedge ref_clk_i);
		dsp_req_o <= 1'b0;
		// released lines must not keep showing the last value
		dsp_va_o <= ~va;
		dsp_we_o <= ~we;
		#1;
		fwd = stc_req_i;
		flt = dsp_fault_i;
		wr = stc_we_i;
		pa = stc_addr_i;
	endtask : access
endmodule : dsp_stc_model

// [testbench/tb_dsp_address_translation_unit.sv]
// self-checking bench for the dsp address translation unit
`timescale 1ns/100ps
module tb_dsp_address_translation_unit;
	import atu_pkg::*;
	// ==========================================================
	// signals and tables
	logic ref_clk_i, rst_n_i, reg_wr, reg_rd, dsp_req, dsp_we, dsp_int;
	logic dsp_fault, stc_req, stc_we, irq;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic [23:0] dsp_va;
	logic [31:0] stc_addr;
	int n_mismatch = 0;
	int compares = 0;
	int cycles = 0;
	logic [4:0] sl[4] = '{5'h00, 5'h1f, 5'h09, 5'h11};
	perm_t pm[4] = '{PERM_RW, PERM_RO, PERM_NONE, PERM_RW};
	logic [31:0] pas[4];
	logic [23:0] vas[4];
	atu_top atu_top_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr),
		.reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
		.reg_rdata_o(reg_rdata), .dsp_req_i(dsp_req), .dsp_we_i(dsp_we),
		.dsp_internal_i(dsp_int), .dsp_va_i(dsp_va), .dsp_fault_o(dsp_fault),
		.stc_req_o(stc_req), .stc_we_o(stc_we), .stc_addr_o(stc_addr), .irq_o(irq));
	dsp_stc_model dsp_stc_model_i (.ref_clk_i(ref_clk_i), .dsp_req_o(dsp_req),
		.dsp_we_o(dsp_we), .dsp_internal_o(dsp_int), .dsp_va_o(dsp_va),
		.dsp_fault_i(dsp_fault), .stc_req_i(stc_req), .stc_we_i(stc_we),
		.stc_addr_i(stc_addr));
	// ==========================================================
	// clock and hang guard
	initial begin
		ref_clk_i = 1'b0;
		forever #2.5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			close_out();
		end
	end
	// ==========================================================
	// compares, verdict and expectation
	task chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, got);
		end
	endtask : chk_val
	task chk_flag(input string nm, input logic exp, input logic got);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %b, seen %b", nm, exp, got);
		end
	endtask : chk_flag
	task close_out();
		$display("mismatches %0d, comparisons %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	// page base from the upper bits, offset below the page size from the low bits
	function automatic logic [31:0] xl(input logic [31:0] hi, input logic [31:0] lo,
		input page_size_t sz);
		int ob;
		logic [31:0] m;
		ob = (sz == PG_1M) ? 20 : (sz == PG_64K) ? 16 : (sz == PG_4K) ? 12 : 10;
		m = (32'h1 << ob) - 32'h1;
		return (hi & ~m) | (lo & m);
	endfunction : xl
	// ==========================================================
	// register port and access tasks
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk_i);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk_i);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge ref_clk_i);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk_i);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask : rd
	// tag words, data words, lock slot, then the load strobe
	task load(input int i);
		wr(REG_TAG_HI, {4'h0, vas[i][23:12]});
		wr(REG_TAG_LO, {vas[i][11:10], 10'h000, sl[i][0], 1'b1, 2'(i)});
		wr(REG_DATA_HI, pas[i][31:16]);
		wr(REG_DATA_LO, {pas[i][15:10], pm[i], 8'h00});
		wr(REG_LOCK, {7'h00, sl[i], 4'h0});
		wr(REG_LOAD, 16'h0001);
	endtask : load
	task acc(input logic we, input logic intl, input logic [23:0] va, input logic ok,
		input logic [31:0] ea);
		logic f, x, w;
		logic [31:0] a;
		dsp_stc_model_i.access(we, intl, va, f, x, w, a);
		chk_flag("forward", ok & !intl, f);
		chk_flag("fault", !ok & !intl, x);
		if (ok & !intl) begin
			chk_val("phys addr", ea, a);
			chk_flag("write", we, w);
		end
	endtask : acc
	task fault_chk(input logic [1:0] st, input logic we, input logic [23:0] va);
		logic [15:0] v;
		rd(REG_IRQ_STAT, v);
		chk_val("status", {30'h0, st}, {16'h0, v});
		chk_flag("irq", 1'b1, irq);
		rd(REG_FAULT_CAUSE, v);
		chk_val("cause", {16'h0, va[7:0], 5'h00, we, st}, {16'h0, v});
		rd(REG_FAULT_ADDR, v);
		chk_val("fault addr", {16'h0, va[23:8]}, {16'h0, v});
		wr(REG_IRQ_STAT, 16'h0003);
		@(posedge ref_clk_i);
		#1;
		chk_flag("irq cleared", 1'b0, irq);
	endtask : fault_chk
	// ==========================================================
	// main sequence
	initial begin
		logic [15:0] v;
		logic [23:0] va;
		rst_n_i = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		void'($urandom(3));
		repeat (10) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		rd(REG_CTRL, v);
		chk_val("ctrl reset", 32'h0, {16'h0, v});
		chk_flag("irq reset", 1'b0, irq);
		rd(4'hf, v);
		chk_val("unmapped", 32'h0, {16'h0, v});
		// passthrough while off, internal accesses ignored
		for (int i = 0; i < 8; i++) begin
			va = 24'($urandom);
			acc(va[0], 1'b0, va, 1'b1, {PASS_HI, va});
			acc(va[1], 1'b1, va, 1'b1, 32'h0);
		end
		// one entry per page size, boundary slots, then enable
		for (int i = 0; i < 4; i++) begin
			pas[i] = $urandom;
			vas[i] = {4'(i + 1), 20'($urandom)};
			load(i);
		end
		wr(REG_CTRL, 16'h0001);
		// a miss with the interrupt masked, then unmasked
		va = {4'hf, 20'($urandom)};
		acc(1'b0, 1'b0, va, 1'b0, 32'h0);
		chk_flag("masked irq", 1'b0, irq);
		wr(REG_IRQ_MASK, 16'h0003);
		fault_chk(2'b01, 1'b0, va);
		// every size and permission, read and write
		for (int i = 0; i < 4; i++) begin
			for (int w = 0; w < 2; w++) begin
				va = 24'(xl({8'h0, vas[i]}, $urandom, page_size_t'(i)));
				acc(w[0], 1'b0, va, pm[i] == PERM_RW || (pm[i] == PERM_RO && !w[0]),
					xl(pas[i], {8'h0, va}, page_size_t'(i)));
				if (!(pm[i] == PERM_RW || (pm[i] == PERM_RO && !w[0])))
					fault_chk(2'b10, w[0], va);
			end
		end
		close_out();
	end
endmodule : tb_dsp_address_translation_unit
